// ==== addr_mode_pkg.sv ====
package addr_mode_pkg;


    // ------------------------------------------------------------
    // Sizes and addresses
    // ------------------------------------------------------------
    localparam int         PC_W          = 12;
    localparam int         STACK_ENTRIES = 6;
    localparam int         BASIC_OPS     = 40;
    localparam int         ADDR_MODES    = 9;
    localparam int         INSTR_TYPES   = 6;
    localparam logic [7:0] SCRATCH_BASE  = 8'h80;
    localparam logic [7:0] PTR_FIRST     = 8'h80;
    localparam logic [7:0] PTR_SECOND    = 8'h81;
    localparam logic [11:0] PC_RESET     = 12'h000;
    localparam logic [7:0] ACC_RESET     = 8'h00;

    // ------------------------------------------------------------
    // Opcode classes (upper bits) and field codes
    // ------------------------------------------------------------
    localparam logic [2:0] CLS_EXT   = 3'h4;
    localparam logic [3:0] CLS_BITD  = 4'hA;
    localparam logic [3:0] CLS_BTB   = 4'hB;
    localparam logic [3:0] CLS_SHORT = 4'hC;
    localparam logic [3:0] CLS_DIR   = 4'hD;
    localparam logic [2:0] CLS_IND   = 3'h7;
    localparam logic [3:0] F_CLEAR   = 4'hD;
    localparam logic [3:0] F_LDIM    = 4'hE;

    // Internal operation codes
    localparam logic [3:0] AOP_LOAD    = 4'h0;
    localparam logic [3:0] AOP_ADD     = 4'h1;
    localparam logic [3:0] AOP_AND     = 4'h2;
    localparam logic [3:0] AOP_COMPARE = 4'h3;
    localparam logic [3:0] AOP_SUB     = 4'h4;
    localparam logic [3:0] AOP_ST      = 4'h5;
    localparam logic [3:0] AOP_INC     = 4'h6;
    localparam logic [3:0] AOP_MINUS   = 4'h7;
    localparam logic [3:0] AOP_CLEAR   = 4'h8;
    localparam logic [3:0] AOP_LDIM    = 4'h9;
    localparam logic [3:0] AOP_INVERT  = 4'hA;
    localparam logic [3:0] AOP_ROTATE  = 4'hB;
    localparam logic [3:0] AOP_SHIFT   = 4'hC;
    localparam logic [3:0] AOP_NOP     = 4'hD;
    localparam logic [3:0] AOP_RET     = 4'hE;

    // ------------------------------------------------------------
    // Cycle counts per instruction type
    // ------------------------------------------------------------
    localparam logic [2:0] CYC_LDST = 3'h4;
    localparam logic [2:0] CYC_ALU  = 3'h4;
    localparam logic [2:0] CYC_REL  = 3'h2;
    localparam logic [2:0] CYC_BTB  = 3'h5;
    localparam logic [2:0] CYC_BIT  = 3'h4;
    localparam logic [2:0] CYC_EXT  = 3'h4;
    localparam logic [2:0] CYC_CTRL = 3'h2;

    typedef enum logic [6:0] {
        S_FETCH = 7'b0000001,
        S_OPND1 = 7'b0000010,
        S_OPND2 = 7'b0000100,
        S_PTR   = 7'b0001000,
        S_RDMEM = 7'b0010000,
        S_EXEC  = 7'b0100000,
        S_HOLD  = 7'b1000000
    } state_t;

    typedef enum logic [5:0] {
        T_LDST    = 6'b000001,
        T_ALU     = 6'b000010,
        T_BRANCH  = 6'b000100,
        T_CTRL    = 6'b001000,
        T_JMPCALL = 6'b010000,
        T_BITMAN  = 6'b100000
    } itype_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } data_req_t;

    typedef struct packed {
        logic [11:0] pc;
        logic [7:0]  acc;
        logic        zero;
        logic        carry;
        logic [2:0]  depth;
    } core_stat_t;

endpackage

// ==== addressing_mode_decoder.sv ====
module addressing_mode_decoder #(
    parameter int STACK_DEPTH = addr_mode_pkg::STACK_ENTRIES
) (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    // Program space, read combinationally at prog_addr
    output logic [addr_mode_pkg::PC_W-1:0]      prog_addr,
    input  wire logic [7:0]                     prog_rdata,
    // Data space, read combinationally at data_req.addr
    output addr_mode_pkg::data_req_t            data_req,
    input  wire logic [7:0]                     data_rdata,
    // Core state
    output addr_mode_pkg::core_stat_t           status,
    output logic                                instr_done,
    output logic                                stack_fault
);
    import addr_mode_pkg::*;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (STACK_DEPTH < 1 || STACK_DEPTH > 7) begin : g_bad_depth
        $error("STACK_DEPTH must lie in 1..7");
    end

    state_t      state;
    logic [7:0]  op;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  mem;
    logic [11:0] pc;
    logic [7:0]  acc;
    logic        zero;
    logic        carry;
    logic [2:0]  cyc;
    logic [2:0]  sp;
    logic [11:0] stack [STACK_DEPTH];
    logic [7:0]  data_addr;
    logic        data_wr;
    logic [7:0]  data_wd;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [7:0] cur_op;
    logic       d_rel, d_ext, d_call, d_bitd, d_btb, d_short;
    logic       d_dir, d_ind, d_imm, d_ldim, d_inh;
    logic [3:0] aop;
    itype_t     d_type;
    logic [2:0] need;

    // Opcode byte is live on the bus during fetch, held afterwards
    assign cur_op = (state == S_FETCH) ? prog_rdata : op;

    always_comb begin
        d_rel   = ~cur_op[7];
        d_ext   = cur_op[7:5] == CLS_EXT;
        d_call  = d_ext & cur_op[4];
        d_bitd  = cur_op[7:4] == CLS_BITD;
        d_btb   = cur_op[7:4] == CLS_BTB;
        d_short = cur_op[7:4] == CLS_SHORT;
        d_dir   = cur_op[7:4] == CLS_DIR;
        d_ind   = cur_op[7:5] == CLS_IND;
        d_imm   = d_dir & cur_op[3] & (cur_op[2:0] <= 3'h4);
        d_ldim  = d_dir & (cur_op[3:0] == F_LDIM);
        d_inh   = d_ind & cur_op[3];
        aop     = AOP_NOP;
        if (d_short) begin
            unique case (cur_op[3:2])
                2'h0: aop = AOP_LOAD;
                2'h1: aop = AOP_ST;
                2'h2: aop = AOP_INC;
                2'h3: aop = AOP_MINUS;
            endcase
        end else if ((d_dir || d_ind) && !cur_op[3]) begin
            aop = {1'b0, cur_op[2:0]};
        end else if (d_imm) begin
            aop = {1'b0, cur_op[2:0]};
        end else if (d_dir && cur_op[3:0] == F_CLEAR) begin
            aop = AOP_CLEAR;
        end else if (d_ldim) begin
            aop = AOP_LDIM;
        end else if (d_inh) begin
            case (cur_op[2:0])
                3'h0:    aop = AOP_INVERT;
                3'h1:    aop = AOP_ROTATE;
                3'h2:    aop = AOP_SHIFT;
                3'h4:    aop = AOP_RET;
                default: aop = AOP_NOP;
            endcase
        end
        // Six instruction types, one cycle budget each except branch, which has two (relative and bit test)
        if (d_rel) begin
            d_type = T_BRANCH;
            need   = CYC_REL;
        end else if (d_btb) begin
            d_type = T_BRANCH;
            need   = CYC_BTB;
        end else if (d_ext) begin
            d_type = T_JMPCALL;
            need   = CYC_EXT;
        end else if (d_bitd) begin
            d_type = T_BITMAN;
            need   = CYC_BIT;
        end else if (aop == AOP_LOAD || aop == AOP_ST || aop == AOP_LDIM) begin
            d_type = T_LDST;
            need   = CYC_LDST;
        end else if (aop == AOP_NOP || aop == AOP_RET) begin
            d_type = T_CTRL;
            need   = CYC_CTRL;
        end else begin
            d_type = T_ALU;
            need   = CYC_ALU;
        end
    end

    // Longer paths than the budget (odd codes) simply end on arrival
    assign instr_done = (state == S_EXEC || state == S_HOLD) && (cyc >= need - 3'h1);

    // ------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------
    logic [7:0]  src;
    logic [8:0]  wide;
    logic [7:0]  new_acc;
    logic        new_z;
    logic        new_c;
    logic        wr_mem;
    logic [7:0]  wdata;
    logic        push;
    logic        pop;
    logic [11:0] pc_next;
    logic [11:0] len;
    logic        bitv;
    logic        cond;

    always_comb begin
        src     = d_imm ? b1 : mem;
        wide    = 9'h000;
        new_acc = acc;
        new_z   = zero;
        new_c   = carry;
        wr_mem  = 1'b0;
        wdata   = 8'h00;
        push    = 1'b0;
        pop     = 1'b0;
        bitv    = mem[cur_op[3:1]];
        len     = (d_btb || d_ldim) ? 12'h003 : ((d_dir || d_bitd || d_ext) ? 12'h002 : 12'h001);
        pc_next = pc + len;
        unique case (cur_op[6:5])
            2'h0: cond = ~zero;
            2'h1: cond = ~carry;
            2'h2: cond = zero;
            2'h3: cond = carry;
        endcase
        if (d_bitd) begin
            // Old bit goes to carry, then the byte is written back
            wr_mem = 1'b1;
            wdata  = mem;
            wdata[cur_op[3:1]] = cur_op[0];
            new_c  = bitv;
        end else if (d_btb) begin
            new_c = bitv;
            if (bitv == cur_op[0]) begin
                pc_next = pc + 12'h001 + {{4{b2[7]}}, b2};
            end
        end else if (d_rel) begin
            if (cond) begin
                pc_next = cur_op[4] ? pc - {8'h00, cur_op[3:0]}
                                    : pc + 12'h001 + {8'h00, cur_op[3:0]};
            end
        end else if (d_ext) begin
            pc_next = {cur_op[3:0], b1};
            push    = d_call;
        end else begin
            case (aop)
                AOP_LOAD: begin
                    new_acc = src;
                    new_z   = (src == 8'h00);
                end
                AOP_ST: begin
                    wr_mem = 1'b1;
                    wdata  = acc;
                    new_z  = (acc == 8'h00);
                end
                AOP_ADD: begin
                    wide    = {1'b0, acc} + {1'b0, src};
                    new_acc = wide[7:0];
                    new_z   = (wide[7:0] == 8'h00);
                    new_c   = wide[8];
                end
                AOP_AND: begin
                    new_acc = acc & src;
                    new_z   = ((acc & src) == 8'h00);
                    new_c   = 1'b0;
                end
                AOP_COMPARE, AOP_SUB: begin
                    wide  = {1'b0, acc} - {1'b0, src};
                    new_z = (wide[7:0] == 8'h00);
                    new_c = wide[8];
                    if (aop == AOP_SUB) begin
                        new_acc = wide[7:0];
                    end
                end
                AOP_INC, AOP_MINUS: begin
                    wr_mem = 1'b1;
                    wdata  = (aop == AOP_INC) ? mem + 8'h01 : mem - 8'h01;
                    new_z  = (wdata == 8'h00);
                end
                AOP_CLEAR: begin
                    wr_mem = 1'b1;
                end
                AOP_LDIM: begin
                    wr_mem = 1'b1;
                    wdata  = b2;
                end
                AOP_INVERT: begin
                    new_acc = ~acc;
                    new_z   = (~acc == 8'h00);
                    new_c   = acc[7];
                end
                AOP_ROTATE, AOP_SHIFT: begin
                    new_acc = {acc[6:0], (aop == AOP_ROTATE) ? carry : 1'b0};
                    new_z   = ({acc[6:0], (aop == AOP_ROTATE) ? carry : 1'b0} == 8'h00);
                    new_c   = acc[7];
                end
                AOP_RET: begin
                    pop = 1'b1;
                    if (sp != 3'h0) begin
                        pc_next = stack[sp - 3'h1];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sequencer and operand capture
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state     <= S_FETCH;
            cyc       <= 3'h0;
            op        <= 8'h00;
            b1        <= 8'h00;
            b2        <= 8'h00;
            mem       <= 8'h00;
            prog_addr <= PC_RESET;
            data_addr <= 8'h00;
        end else begin
            cyc <= cyc + 3'h1;
            unique case (state)
                S_FETCH: begin
                    op  <= prog_rdata;
                    cyc <= 3'h1;
                    if (d_rel || d_inh) begin
                        state <= S_EXEC;
                    end else if (d_short) begin
                        state     <= S_RDMEM;
                        data_addr <= SCRATCH_BASE | {6'h00, prog_rdata[1:0]};
                    end else if (d_ind) begin
                        state     <= S_PTR;
                        data_addr <= prog_rdata[4] ? PTR_SECOND : PTR_FIRST;
                    end else begin
                        state     <= S_OPND1;
                        prog_addr <= pc + 12'h001;
                    end
                end
                S_OPND1: begin
                    b1 <= prog_rdata;
                    if (d_btb || d_ldim) begin
                        state     <= S_OPND2;
                        prog_addr <= pc + 12'h002;
                    end else if (d_imm || d_ext) begin
                        state <= S_EXEC;
                    end else begin
                        state     <= S_RDMEM;
                        data_addr <= prog_rdata;
                    end
                end
                S_OPND2: begin
                    b2        <= prog_rdata;
                    data_addr <= b1;
                    state     <= d_btb ? S_RDMEM : S_EXEC;
                end
                S_PTR: begin
                    data_addr <= data_rdata;
                    state     <= S_RDMEM;
                end
                S_RDMEM: begin
                    mem   <= data_rdata;
                    state <= S_EXEC;
                end
                S_EXEC, S_HOLD: begin
                    if (instr_done) begin
                        state     <= S_FETCH;
                        prog_addr <= (state == S_EXEC) ? pc_next : pc;
                    end else begin
                        state <= S_HOLD;
                    end
                end
                default: state <= S_FETCH;
            endcase
        end
    end

    // Accumulator, flags and program counter change only in execute
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc   <= ACC_RESET;
            zero  <= 1'b0;
            carry <= 1'b0;
            pc    <= PC_RESET;
        end else if (state == S_EXEC) begin
            acc   <= new_acc;
            zero  <= new_z;
            carry <= new_c;
            pc    <= pc_next;
        end
    end

    // Return stack; overflow and underflow latch a fault, nothing wraps
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sp          <= 3'h0;
            stack_fault <= 1'b0;
        end else if (state == S_EXEC) begin
            if (push) begin
                if (sp < 3'(STACK_DEPTH)) begin
                    stack[sp] <= pc + len;
                    sp        <= sp + 3'h1;
                end else begin
                    stack_fault <= 1'b1;
                end
            end else if (pop) begin
                if (sp != 3'h0) begin
                    sp <= sp - 3'h1;
                end else begin
                    stack_fault <= 1'b1;
                end
            end
        end
    end

    // Write strobe lands one cycle after execute, address still held
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_wr <= 1'b0;
            data_wd <= 8'h00;
        end else begin
            data_wr <= (state == S_EXEC) && wr_mem;
            data_wd <= wdata;
        end
    end

    assign data_req = '{addr: data_addr, wr: data_wr, wdata: data_wd};
    assign status   = '{pc: pc, acc: acc, zero: zero, carry: carry, depth: sp};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    ldst_length_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == S_FETCH && d_type == T_LDST
        |-> !instr_done ##1 !instr_done ##1 !instr_done ##1 instr_done)
        else $error("load or store not four cycles");
    rel_length_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == S_FETCH && d_rel |-> !instr_done ##1 instr_done)
        else $error("relative branch not two cycles");
    btb_length_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == S_FETCH && d_btb |-> !instr_done[*4] ##1 instr_done)
        else $error("bit test branch not five cycles");
    stack_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        sp <= 3'(STACK_DEPTH))
        else $error("return stack beyond its depth");
    rel_target_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == S_EXEC && d_rel && cond && cur_op[4]
        |=> pc == $past(pc) - {8'h00, $past(op[3:0])})
        else $error("backward branch target wrong");
    ext_target_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == S_EXEC && d_ext |=> pc == {$past(op[3:0]), $past(b1)})
        else $error("extended target wrong");
    short_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == S_FETCH && d_short ##1 state == S_RDMEM
        |-> data_addr == (SCRATCH_BASE | {6'h00, op[1:0]}))
        else $error("short direct address wrong");
    bit_carry_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == S_EXEC && d_bitd
        |=> carry == $past(bitv) ##0 data_wr && data_wd[op[3:1]] == op[0])
        else $error("bit op carry or write wrong");
    ldim_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == S_EXEC && d_ldim |=> $stable(zero) && $stable(carry) && data_wr)
        else $error("immediate store touched flags");

endmodule // addressing_mode_decoder

// ==== mem_model.sv ====
// ------------------------------------------------------------
// Program and data space model
// ------------------------------------------------------------
module mem_model (
    // Clock
    input  wire logic                   clk,
    // Program space
    input  wire logic [11:0]            prog_addr,
    output logic [7:0]                  prog_rdata,
    // Data space
    input  wire addr_mode_pkg::data_req_t data_req,
    output logic [7:0]                  data_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    import addr_mode_pkg::*;

    logic [7:0] prog [4096];
    logic [7:0] dmem [256];

    // Asynchronous reads, as the core expects no wait state
    assign prog_rdata = prog[prog_addr];
    assign data_rdata = dmem[data_req.addr];

    // Write on the strobe edge; all 256 bytes writable
    // Plain always, since the bench also preloads this array directly
    always @(posedge clk) begin
        if (data_req.wr) begin
            dmem[data_req.addr] <= data_req.wdata;
        end
    end
endmodule // mem_model

// ==== testbench.sv ====
// ------------------------------------------------------------
// Self-checking bench for the addressing decoder
// ------------------------------------------------------------
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import addr_mode_pkg::*;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] prog_addr;
    logic [7:0]  prog_rdata;
    logic [7:0]  data_rdata;
    data_req_t   data_req;
    core_stat_t  status;
    logic        instr_done;
    logic        stack_fault;
    logic [11:0] seen;
    int          n_mismatch = 0;
    int          n_checks = 0;

    // Clock of 40 ns period
    always #20 clk = ~clk;

    addressing_mode_decoder dut_u (.clk(clk), .rst_n(rst_n), .prog_addr(prog_addr),
        .prog_rdata(prog_rdata), .data_req(data_req), .data_rdata(data_rdata),
        .status(status), .instr_done(instr_done), .stack_fault(stack_fault));
    mem_model mem_u (.clk(clk), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
        .data_req(data_req), .data_rdata(data_rdata));

    task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Hold reset 5 cycles and fill program space with no-ops
    task boot;
        @(posedge clk);
        rst_n <= 1'b0;
        for (int k = 0; k < 4096; k++) mem_u.prog[k] = 8'hEB;
        repeat (5) @(posedge clk);
    endtask

    // Release reset, wait for n completions, then note the next fetch address
    task run(input int n);
        int cnt;
        cnt = 0;
        rst_n <= 1'b1;
        for (int k = 0; k < 200 && cnt < n; k++) begin
            @(negedge clk);
            if (instr_done === 1'b1) cnt++;
        end
        chk("completions", n, cnt);
        @(negedge clk);
        seen = prog_addr;
        repeat (2) @(negedge clk);
    endtask

    // Immediate load, direct store, zero flag set by a load of zero
    task t_load_store;
        boot();
        {mem_u.prog[0], mem_u.prog[1], mem_u.prog[2]} = {8'hD8, 8'h5A, 8'hD5};
        {mem_u.prog[3], mem_u.prog[4], mem_u.prog[5]} = {8'hA0, 8'hD8, 8'h00};
        run(3);
        chk("stored byte", 12'h05A, mem_u.dmem[8'hA0]);
        chk("acc", 12'h000, status.acc);
        chk("zero", 12'h001, status.zero);
        $display("test load_store done");
    endtask

    // Short direct store to 81h, then indirect load through it
    task t_short_ind;
        boot();
        mem_u.dmem[8'h3C] = 8'hA5;
        {mem_u.prog[0], mem_u.prog[1], mem_u.prog[2], mem_u.prog[3]} = 32'hD83CC5F0;
        run(3);
        chk("scratch byte", 12'h03C, mem_u.dmem[8'h81]);
        chk("acc", 12'h0A5, status.acc);
        $display("test short_ind done");
    endtask

    // Immediate to memory leaves zero flag alone
    task t_ldim;
        boot();
        {mem_u.prog[0], mem_u.prog[1]} = {8'hD8, 8'h00};
        {mem_u.prog[2], mem_u.prog[3], mem_u.prog[4]} = {8'hDE, 8'hFF, 8'h99};
        run(2);
        chk("written byte", 12'h099, mem_u.dmem[8'hFF]);
        chk("zero", 12'h001, status.zero);
        $display("test ldim done");
    endtask

    // Clear bit 3; old bit lands in carry
    task t_bit;
        boot();
        mem_u.dmem[8'h40] = 8'h08;
        {mem_u.prog[0], mem_u.prog[1]} = {8'hA6, 8'h40};
        run(1);
        chk("bit target", 12'h000, mem_u.dmem[8'h40]);
        chk("carry", 12'h001, status.carry);
        $display("test bit done");
    endtask

    // Extended call joins nibble and byte, one stack entry used
    task t_call;
        boot();
        {mem_u.prog[0], mem_u.prog[1]} = {8'h95, 8'h23};
        run(1);
        chk("call target", 12'h523, seen);
        chk("depth", 12'h001, status.depth);
        $display("test call done");
    endtask

    // Forward span F, backward span F, then an untaken branch
    task t_branch;
        boot();
        {mem_u.prog[0], mem_u.prog[12'h010], mem_u.prog[1]} = {8'h0F, 8'h1F, 8'h45};
        run(1);
        chk("forward target", 12'h010, seen);
        // Reset again but keep the program: forward, backward, untaken
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        run(3);
        chk("fall through", 12'h002, seen);
        $display("test branch done");
    endtask

    // Call and return, taken bit test branch, then a return on an empty stack
    task t_return;
        boot();
        mem_u.dmem[8'h40] = 8'h08;
        {mem_u.prog[0], mem_u.prog[1], mem_u.prog[12'h110]} = {8'h91, 8'h10, 8'hEC};
        {mem_u.prog[2], mem_u.prog[3], mem_u.prog[4], mem_u.prog[8]} = 32'hB74005EC;
        run(4);
        chk("return chain", 12'h009, seen);
        chk("pc after no-op", 12'h00A, status.pc);
        chk("carry", 12'h001, status.carry);
        chk("depth", 12'h000, status.depth);
        chk("stack fault", 12'h001, stack_fault);
        $display("test return done");
    endtask

    task stop_test;
        $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Watchdog, far beyond the 125 cycles the tests take
    initial begin
        #400000;
        n_mismatch++;
        stop_test();
    end

    initial begin
        t_load_store();
        t_short_ind();
        t_ldim();
        t_bit();
        t_call();
        t_branch();
        t_return();
        stop_test();
    end
endmodule // testbench
